// ===== verilog/clock_status_readback_monitor.sv
// Clock status readback registers and status monitor pin multiplexer
//
// What this block does
// - Bit 7 shows output loop reference present
// - Bit 6 shows input loop feedback present
// - Bits 5..2 show VCXO, test, secondary, primary
// - Bits 1,0 show output, input loop lock
// - Second register bit 3 shows holdover
// - Bit 2 shows automatically chosen reference
// - Bit 0 shows VCO calibration running
// - Six-bit field picks monitor pin; zero drives low
// - Codes 1..3 give lock indications
// - Codes 4,5 give references lost conditions
// - Code 6 gives secondary chosen indication
// - Codes 7..12 give single presence flags
// - Code 13 reserved; 14,15 give combined presence
// - Codes 16..19 halved diagnostics; 20..23 low
`timescale 1ns/1ps
`default_nettype none

module clock_status_readback_monitor
    import clock_status_pkg::*;
#(
    parameter int DIAG_WIDTH = DIAG_N
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire reg_req_s      reg_req,
    output logic        [7:0]  rd_data,
    output logic               rd_valid,
    input  wire clock_status_s status,
    input  wire diag_s         diag,
    output logic               monitor0
);

    // Whole state of this block
    typedef struct packed {
        logic [5:0] mon0_sel;   // Monitor pin selection field
        logic [7:0] rd_data;    // Held read answer
        logic       rd_valid;   // Answer marker, one cycle
        logic       monitor0;   // Registered monitor pin level
    } mon_state_s;

    mon_state_s       state_reg;    // Registered state
    mon_state_s       state_next;   // Next state
    logic [DIAG_WIDTH-1:0] diag_half; // Halved diagnostic signals
    logic [7:0]       presence_byte; // First readback image
    logic [7:0]       holdover_byte; // Second readback image
    logic             mon_level;    // Multiplexer output

    // Halved-rate copies of the loop diagnostics
    half_rate_divider #(
        .WIDTH    (DIAG_WIDTH)
    ) u_half (
        .clk      (clk),
        .rst      (rst),
        .sig_in   (diag),
        .half_out (diag_half)
    );

    // Image of the presence and lock register
    function automatic logic [7:0] presence_image(input clock_status_s s);
        logic [7:0] b;
        b                  = 8'h00;
        b[BIT_OUT_REF_OK]  = s.out_ref_ok;
        b[BIT_IN_FB_OK]    = s.in_fb_ok;
        b[BIT_VCXO_OK]     = s.vcxo_ok;
        b[BIT_TEST_REF_OK] = s.test_ref_ok;
        b[BIT_SEC_REF_OK]  = s.sec_ref_ok;
        b[BIT_PRI_REF_OK]  = s.pri_ref_ok;
        b[BIT_OUT_LOCK]    = s.out_lock;
        b[BIT_IN_LOCK]     = s.in_lock;
        return b;
    endfunction

    // Image of the holdover, selection and calibration register
    function automatic logic [7:0] holdover_image(input clock_status_s s);
        logic [7:0] b;
        // Reserved bits stay zero
        b                   = 8'h00;
        b[BIT_HOLDOVER]     = s.holdover;
        // Only meaningful under automatic selection; passed as is
        b[BIT_AUTO_SEC_SEL] = s.auto_sec_sel;
        b[BIT_VCO_CAL]      = s.vco_cal_busy;
        return b;
    endfunction

    // Both references gone
    function automatic logic refs_lost(input clock_status_s s);
        return ~s.pri_ref_ok & ~s.sec_ref_ok;
    endfunction

    assign presence_byte = presence_image(status);
    assign holdover_byte = holdover_image(status);

    // Monitor pin multiplexer
    always_comb
    begin
        mon_level = 1'b0;
        unique case (state_reg.mon0_sel)
            // Ground selection drives low
            SEL_GND:        mon_level = 1'b0;
            // Lock indications
            SEL_BOTH_LOCK:  mon_level = status.in_lock
                                        & status.out_lock;
            SEL_IN_LOCK:    mon_level = status.in_lock;
            SEL_OUT_LOCK:   mon_level = status.out_lock;
            // Reference loss
            SEL_REFS_LOST:  mon_level = refs_lost(status);
            SEL_LOST_OLOCK: mon_level = refs_lost(status)
                                        & status.out_lock;
            // Valid only while selection is automatic
            SEL_SEC_CHOSEN: mon_level = status.auto_sec_sel;
            // Single presence flags
            SEL_PRI_OK:     mon_level = status.pri_ref_ok;
            SEL_SEC_OK:     mon_level = status.sec_ref_ok;
            SEL_TEST_OK:    mon_level = status.test_ref_ok;
            SEL_VCXO_OK:    mon_level = status.vcxo_ok;
            SEL_IN_FB_OK:   mon_level = status.in_fb_ok;
            SEL_OUT_REF_OK: mon_level = status.out_ref_ok;
            // Reserved code kept quiet rather than guessed
            SEL_RESERVED:   mon_level = 1'b0;
            SEL_REFS_OK:    mon_level = status.pri_ref_ok
                                        & status.sec_ref_ok;
            // Test reference deliberately left out
            SEL_ALL_OK:     mon_level = status.pri_ref_ok
                                        & status.sec_ref_ok
                                        & status.vcxo_ok
                                        & status.in_fb_ok
                                        & status.out_ref_ok;
            // Halved diagnostics, bit order follows diag_s
            SEL_HALF_FB:    mon_level = diag_half[0];
            SEL_HALF_DN:    mon_level = diag_half[1];
            SEL_HALF_REF:   mon_level = diag_half[2];
            SEL_HALF_UP:    mon_level = diag_half[3];
            // Codes 20 to 23, and illegal codes above 23, drive low
            default:        mon_level = 1'b0;
        endcase
    end

    // Register access and pin update
    always_comb
    begin
        state_next          = state_reg;
        state_next.rd_valid = 1'b0;
        state_next.monitor0 = mon_level;
        // Writes: only the selection register is writable
        if (reg_req.wr)
        begin
            if (reg_req.addr == ADDR_MON0_SEL)
            begin
                // Upper two bits reserved and dropped
                state_next.mon0_sel = reg_req.wdata[SEL_W-1:0];
            end
            // Readback addresses take no write
        end
        // Reads: answer one cycle later; unmapped reads zero
        if (reg_req.rd)
        begin
            state_next.rd_valid = 1'b1;
            unique case (reg_req.addr)
                ADDR_PRESENCE: state_next.rd_data = presence_byte;
                ADDR_HOLDOVER: state_next.rd_data = holdover_byte;
                ADDR_MON0_SEL: state_next.rd_data =
                                   {2'b00, state_reg.mon0_sel};
                default:       state_next.rd_data = 8'h00;
            endcase
        end
    end

    // State register; selection resets to ground
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg          <= '0;
            state_reg.mon0_sel <= MON0_SEL_RST[SEL_W-1:0];
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_data  = state_reg.rd_data;
    assign rd_valid = state_reg.rd_valid;
    assign monitor0 = state_reg.monitor0;

endmodule

`default_nettype wire

// ===== inc/clock_status_pkg.sv
// Shared constants and carriers for the clock status readback block
package clock_status_pkg;

    // Register addresses of the control port space
    localparam int          ADDR_W            = 12;
    localparam logic [11:0] ADDR_PRESENCE     = 12'h22C;
    localparam logic [11:0] ADDR_HOLDOVER     = 12'h22D;
    localparam logic [11:0] ADDR_MON0_SEL     = 12'h230;

    // Field positions in the presence and lock register
    localparam int BIT_OUT_REF_OK   = 7;
    localparam int BIT_IN_FB_OK     = 6;
    localparam int BIT_VCXO_OK      = 5;
    localparam int BIT_TEST_REF_OK  = 4;
    localparam int BIT_SEC_REF_OK   = 3;
    localparam int BIT_PRI_REF_OK   = 2;
    localparam int BIT_OUT_LOCK     = 1;
    localparam int BIT_IN_LOCK      = 0;

    // Field positions in the holdover and selection register
    localparam int BIT_HOLDOVER     = 3;
    localparam int BIT_AUTO_SEC_SEL = 2;
    localparam int BIT_VCO_CAL      = 0;

    // Monitor selection field
    localparam int         SEL_W         = 6;
    localparam logic [7:0] MON0_SEL_RST  = 8'h00;

    // Monitor selection codes
    localparam logic [5:0] SEL_GND        = 6'h00;
    localparam logic [5:0] SEL_BOTH_LOCK  = 6'h01;
    localparam logic [5:0] SEL_IN_LOCK    = 6'h02;
    localparam logic [5:0] SEL_OUT_LOCK   = 6'h03;
    localparam logic [5:0] SEL_REFS_LOST  = 6'h04;
    localparam logic [5:0] SEL_LOST_OLOCK = 6'h05;
    localparam logic [5:0] SEL_SEC_CHOSEN = 6'h06;
    localparam logic [5:0] SEL_PRI_OK     = 6'h07;
    localparam logic [5:0] SEL_SEC_OK     = 6'h08;
    localparam logic [5:0] SEL_TEST_OK    = 6'h09;
    localparam logic [5:0] SEL_VCXO_OK    = 6'h0A;
    localparam logic [5:0] SEL_IN_FB_OK   = 6'h0B;
    localparam logic [5:0] SEL_OUT_REF_OK = 6'h0C;
    localparam logic [5:0] SEL_RESERVED   = 6'h0D;
    localparam logic [5:0] SEL_REFS_OK    = 6'h0E;
    localparam logic [5:0] SEL_ALL_OK     = 6'h0F;
    localparam logic [5:0] SEL_HALF_FB    = 6'h10;
    localparam logic [5:0] SEL_HALF_DN    = 6'h11;
    localparam logic [5:0] SEL_HALF_REF   = 6'h12;
    localparam logic [5:0] SEL_HALF_UP    = 6'h13;
    localparam logic [5:0] SEL_LAST_GND   = 6'h17;

    // Number of diagnostic signals that are halved in rate
    localparam int DIAG_N = 4;

    // Live status flags from the loops and reference logic
    typedef struct packed {
        logic out_ref_ok;     // Output loop reference clock present
        logic in_fb_ok;       // Input loop feedback clock present
        logic vcxo_ok;        // Oscillator clock present
        logic test_ref_ok;    // Test reference present
        logic sec_ref_ok;     // Secondary reference present
        logic pri_ref_ok;     // Primary reference present
        logic out_lock;       // Output synthesis loop locked
        logic in_lock;        // Input cleanup loop locked
        logic holdover;       // Holdover in effect
        logic auto_sec_sel;   // Automatic selection chose secondary
        logic vco_cal_busy;   // VCO calibration running
    } clock_status_s;

    // Diagnostic signals of the input cleanup loop
    typedef struct packed {
        logic up;             // Phase detector up pulse
        logic ref_clk;        // Reference at the phase detector
        logic down;           // Phase detector down pulse
        logic feedback;       // Feedback at the phase detector
    } diag_s;

    // One register request from the serial control port
    typedef struct packed {
        logic        rd;      // Read strobe
        logic        wr;      // Write strobe
        logic [11:0] addr;    // Register address
        logic [7:0]  wdata;   // Write data
    } reg_req_s;

endpackage

// ===== verilog/half_rate_divider.sv
// Divide-by-two of several synchronous diagnostic signals
`timescale 1ns/1ps
`default_nettype none

module half_rate_divider
    import clock_status_pkg::*;
#(
    parameter int WIDTH = DIAG_N
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] sig_in,
    output logic      [WIDTH-1:0] half_out
);

    // Whole state of the divider
    typedef struct packed {
        logic [WIDTH-1:0] prev;   // Last sample of each input
        logic [WIDTH-1:0] half;   // Toggle outputs
    } div_state_s;

    div_state_s       state_reg;  // Registered state
    div_state_s       state_next; // Next state
    logic [WIDTH-1:0] rise;       // Rising edge per input

    // One edge detector per input; each toggles its own half-rate copy
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_edge
            assign rise[i] = sig_in[i] & ~state_reg.prev[i];
        end
    endgenerate

    // Next state: sample inputs, toggle on each rising edge
    always_comb
    begin
        state_next      = state_reg;
        state_next.prev = sig_in;
        state_next.half = state_reg.half ^ rise;
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign half_out = state_reg.half;

endmodule

`default_nettype wire

// ===== sim/clock_status_readback_monitor_sva.sv
// Assertion checker for the clock status readback block
`timescale 1ns/1ps
`default_nettype none

module clock_status_checker
    import clock_status_pkg::*;
#(
    parameter int DIAG_WIDTH = DIAG_N
)
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire reg_req_s      reg_req,
    input  wire logic [7:0]    rd_data,
    input  wire logic          rd_valid,
    input  wire clock_status_s status,
    input  wire diag_s         diag,
    input  wire logic          monitor0
);
    logic [5:0]  sel_reg;  // Shadow of the selection field
    logic [10:0] st;       // Flags as a plain vector
    logic        rd_p;     // Read of presence register
    logic        rd_h;     // Read of holdover register
    logic        rd_s;     // Read of selection register
    logic        half;     // A halved diagnostic is selected
    logic        low;      // A grounded code is selected
    assign st   = status;
    assign rd_p = reg_req.rd && reg_req.addr == ADDR_PRESENCE;
    assign rd_h = reg_req.rd && reg_req.addr == ADDR_HOLDOVER;
    assign rd_s = reg_req.rd && reg_req.addr == ADDR_MON0_SEL;
    assign half = sel_reg[5:2] == 4'h4;
    assign low  = sel_reg == SEL_GND || sel_reg == SEL_RESERVED
                  || (sel_reg >= 6'h14 && sel_reg <= SEL_LAST_GND);

    // Shadow tracks writes; upper data bits never land
    always_ff @(posedge clk)
        if (rst)
            sel_reg <= 6'h00;
        else if (reg_req.wr && reg_req.addr == ADDR_MON0_SEL)
            sel_reg <= reg_req.wdata[5:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    read_answer_a:
        assert property (reg_req.rd |=> rd_valid) else $error("No answer");
    no_stray_a:
        assert property (rd_valid |-> $past(reg_req.rd)) else $error("Stray");
    presence_a:
        assert property (rd_p |=> rd_data == $past(st[10:3]))
        else $error("Presence readback wrong");
    holdover_a:
        assert property (rd_h |=> rd_data == {4'h0, $past(st[2:1]), 1'b0,
            $past(st[0])}) else $error("Holdover readback wrong");
    sel_read_a:
        assert property (rd_s |=> rd_data == {2'b00, $past(sel_reg)})
        else $error("Selection readback wrong");
    unmapped_a:
        assert property (reg_req.rd && !rd_p && !rd_h && !rd_s |=>
            rd_data == 8'h00) else $error("Unmapped read not zero");
    mon_low_a:
        assert property (low |=> !monitor0) else $error("Pin not low");
    mon_lock_a:
        assert property (sel_reg == SEL_BOTH_LOCK |=>
            monitor0 == $past(status.in_lock && status.out_lock))
        else $error("Lock code wrong");
    in_lock_pin_a:
        assert property (sel_reg == SEL_IN_LOCK |=>
            monitor0 == $past(status.in_lock))
        else $error("Input lock code wrong");
    out_lock_pin_a:
        assert property (sel_reg == SEL_OUT_LOCK |=>
            monitor0 == $past(status.out_lock))
        else $error("Output lock code wrong");
    refs_lost_a:
        assert property (sel_reg == SEL_REFS_LOST |=>
            monitor0 == $past(!status.pri_ref_ok && !status.sec_ref_ok))
        else $error("Lost code wrong");
    lost_locked_a:
        assert property (sel_reg == SEL_LOST_OLOCK |=>
            monitor0 == $past(!status.pri_ref_ok && !status.sec_ref_ok
            && status.out_lock))
        else $error("Lost and locked code wrong");
    sec_chosen_a:
        assert property (sel_reg == SEL_SEC_CHOSEN |=>
            monitor0 == $past(status.auto_sec_sel))
        else $error("Secondary chosen code wrong");
    refs_ok_a:
        assert property (sel_reg == SEL_REFS_OK |=>
            monitor0 == $past(status.pri_ref_ok && status.sec_ref_ok))
        else $error("Both present code wrong");
    all_ok_a:
        assert property (sel_reg == SEL_ALL_OK |=>
            monitor0 == $past(status.pri_ref_ok && status.sec_ref_ok
            && status.vcxo_ok && status.in_fb_ok && status.out_ref_ok))
        else $error("All present code wrong");
    mon_flag_a:
        assert property (sel_reg >= SEL_PRI_OK && sel_reg <= SEL_OUT_REF_OK
            |=> monitor0 == $past(st[sel_reg - 6'd2]))
        else $error("Flag code wrong");
    half_rate_a:
        assert property ($changed(monitor0) && half && $stable(sel_reg)
            && $past(sel_reg, 2) == sel_reg |=> $stable(monitor0))
        else $error("Halved output too fast");

    cover property (reg_req.rd && reg_req.wr);
    cover property (half && $changed(monitor0));
    cover property (rd_valid && rd_data == 8'hFF);
endmodule

bind clock_status_readback_monitor clock_status_checker
    #(.DIAG_WIDTH(DIAG_WIDTH)) chk_i (.clk(clk), .rst(rst),
    .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .status(status), .diag(diag), .monitor0(monitor0));
`default_nettype wire

// ===== sim/test_clock_status_readback_monitor.sv
// Self-checking bench for the clock status readback block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h exp %h", $time, a, b); end end

module test_clock_status_readback_monitor
    import clock_status_pkg::*;
;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    reg_req_s      reg_req = '0;
    clock_status_s status = '0;
    diag_s         diag = '0;
    logic [7:0]    rd_data;
    logic          rd_valid;
    logic          monitor0;
    logic [7:0]    d;
    int            errors = 0;
    int            tests_run = 0;

    clock_status_readback_monitor #(.DIAG_WIDTH(DIAG_N)) dut (.clk(clk),
        .rst(rst), .reg_req(reg_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .status(status), .diag(diag),
        .monitor0(monitor0));

    // 100 MHz clock
    always #5 clk = ~clk;

    // Step to just after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One request; idle edge after it keeps strobes from merging
    task automatic bus(input logic r, input logic w, input logic [11:0] a,
                       input logic [7:0] wd);
        reg_req = '{rd: r, wr: w, addr: a, wdata: wd};
        tick(1);
        d = rd_data;
        if (r) `CHK(rd_valid, 1'b1)
        reg_req = '0;
        tick(1);
        `CHK(rd_valid, 1'b0)
    endtask

    // Expected pin for the level codes below 16
    function automatic logic mon_exp(input logic [5:0] c,
                                     input clock_status_s s);
        logic [15:0] v;
        v = {s.pri_ref_ok & s.sec_ref_ok & s.vcxo_ok & s.in_fb_ok
             & s.out_ref_ok, s.pri_ref_ok & s.sec_ref_ok, 1'b0,
             s.out_ref_ok, s.in_fb_ok, s.vcxo_ok, s.test_ref_ok,
             s.sec_ref_ok, s.pri_ref_ok, s.auto_sec_sel,
             ~s.pri_ref_ok & ~s.sec_ref_ok & s.out_lock,
             ~s.pri_ref_ok & ~s.sec_ref_ok, s.out_lock, s.in_lock,
             s.in_lock & s.out_lock, 1'b0};
        return (c < 6'h10) ? v[c[3:0]] : 1'b0;
    endfunction

    // Quiet pin and zero selection after reset
    task automatic t_reset;
        `CHK(monitor0, 1'b0)
        bus(1'b1, 1'b0, ADDR_MON0_SEL, 8'h00);
        `CHK(d, 8'h00)
    endtask

    // Walking ones through both readback registers, then writes
    task automatic t_readback;
        for (int i = 0; i < 12; i++)
        begin
            status = (i == 11) ? '1 : clock_status_s'(11'(1) << i);
            bus(1'b1, 1'b0, ADDR_PRESENCE, 8'h00);
            `CHK(d, status[10:3])
            bus(1'b1, 1'b0, ADDR_HOLDOVER, 8'h00);
            `CHK(d, {4'h0, status[2:1], 1'b0, status[0]})
        end
        bus(1'b0, 1'b1, ADDR_PRESENCE, 8'h00);
        bus(1'b0, 1'b1, 12'h22E, 8'h5A);
        bus(1'b1, 1'b0, ADDR_PRESENCE, 8'h00);
        `CHK(d, 8'hFF)
        bus(1'b1, 1'b0, 12'h22E, 8'h00);
        `CHK(d, 8'h00)
    endtask

    // Same-edge read and write returns the old selection
    task automatic t_select;
        bus(1'b0, 1'b1, ADDR_MON0_SEL, 8'h05);
        // Top bits set to show they drop; the field itself stays legal
        bus(1'b1, 1'b1, ADDR_MON0_SEL, 8'hD7);
        `CHK(d, 8'h05)
        bus(1'b1, 1'b0, ADDR_MON0_SEL, 8'h00);
        `CHK(d, 8'h17)
    endtask

    // Every level code against walking ones and zeros; no code above 23
    task automatic t_mux;
        logic e;
        for (int c = 0; c < 24; c++)
        begin
            if (c >= 16 && c < 20)
                continue;
            bus(1'b0, 1'b1, ADDR_MON0_SEL, 8'hC0 | 8'(c));
            for (int i = 0; i < 22; i++)
            begin
                status = clock_status_s'(11'(1) << (i % 11));
                if (i >= 11)
                    status = ~status;
                tick(2);
                e = mon_exp(6'(c), status);
                `CHK(monitor0, e)
            end
        end
    endtask

    // Ten rises on one diagnostic give ten pin toggles
    task automatic t_half;
        int   n;
        logic m;
        for (int j = 0; j < 4; j++)
        begin
            bus(1'b0, 1'b1, ADDR_MON0_SEL, 8'(16 + j));
            n = 0;
            m = monitor0;
            for (int k = 0; k < 26; k++)
            begin
                diag = diag_s'(4'(k < 20 && k % 2 == 1) << j);
                tick(1);
                n += (monitor0 !== m);
                m = monitor0;
            end
            `CHK(n, 10)
        end
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        tick(5);
        rst = 1'b0;
        t_reset;
        t_readback;
        t_select;
        t_mux;
        t_half;
        close_out;
    end

    // Hang guard, about four and a half times the expected run of some 1100 cycles
    initial
    begin
        #50000;
        errors++;
        close_out;
    end
endmodule
`default_nettype wire
